//--- rtl/uart_rx_pkg.sv
// Shared constants for the serial receiver with address detect and wake.
// Assumes an APB slave with 32-bit data; each register is one aligned word.
package uart_rx_pkg;

   // Register byte offsets on the APB
   localparam logic [7:0] OFS_RX_STATUS = 8'h00; // Receive status/control
   localparam logic [7:0] OFS_RX_DATA   = 8'h04; // Receive data, read only
   localparam logic [7:0] OFS_TX_STATUS = 8'h08; // Transmit status/control
   localparam logic [7:0] OFS_BAUD_CTRL = 8'h0C; // Baud control
   localparam logic [7:0] OFS_DIV_HIGH  = 8'h10; // Baud divisor high byte
   localparam logic [7:0] OFS_DIV_LOW   = 8'h14; // Baud divisor low byte
   localparam logic [7:0] OFS_INT_CTRL  = 8'h18; // Flag and enables

   // Receive status/control fields
   localparam int RS_PORT_EN = 7;
   localparam int RS_NINE    = 6;
   localparam int RS_SINGLE  = 5;
   localparam int RS_CONT    = 4;
   localparam int RS_ADDR    = 3;
   localparam int RS_FRAMING_ERROR_FLAG    = 2;
   localparam int RS_OVERRUN_ERROR_FLAG    = 1;
   localparam int RS_NINTH   = 0;

   // Transmit status/control fields used here
   localparam int TS_SYNC  = 4;
   localparam int TS_HIGH  = 2;

   // Baud control fields
   localparam int BC_IDLE  = 6;
   localparam int BC_WIDE  = 3;
   localparam int BC_WAKE  = 1;

   // Interrupt control fields
   localparam int IC_FLAG  = 0;
   localparam int IC_IE    = 1;
   localparam int IC_GIE   = 2;

   // Reset value of every register byte
   localparam logic [7:0] RESET_BYTE = 8'h00;

   // Baud scaling: clocks per bit per divisor step
   localparam logic [23:0] SCALE_SLOW = 24'h000040; // 64
   localparam logic [23:0] SCALE_MID  = 24'h000010; // 16
   localparam logic [23:0] SCALE_FAST = 24'h000004; // 4
   localparam logic [23:0] OVERSAMPLE = 24'h000010; // 16 ticks a bit

   // Tick positions within a bit and last data bit index
   localparam logic [3:0] MID_TICK   = 4'h7;
   localparam logic [3:0] LAST_TICK  = 4'hF;
   localparam logic [3:0] LAST_EIGHT = 4'h7;
   localparam logic [3:0] LAST_NINE  = 4'h8;

   // Receiver states, Gray coded along the frame
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_DATA  = 2'b11,
      ST_STOP  = 2'b10
   } rx_state_t;

endpackage

//--- rtl/rx_baud_gen.sv
// Baud generator giving a sample tick at sixteen times the bit rate, or every clock when a bit is under 16 clocks.
// Assumes the divisor and selects come from registers on the same clock.
`timescale 1ns/1ns
module rx_baud_gen
   import uart_rx_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        run,
   input  wire logic        high_speed,
   input  wire logic        wide,
   input  wire logic [15:0] divisor,
   output logic             sample_tick
);

   logic [23:0] scale;      // Clocks per bit per divisor step
   logic [23:0] bit_period; // Clocks per bit
   logic [23:0] acc;        // Phase accumulator
   logic [23:0] next_acc;   // Accumulator plus one clock of phase

   // Pick the scale from the two select bits
   always_comb begin
      case ({wide, high_speed})
         2'b00:   scale = SCALE_SLOW;
         2'b11:   scale = SCALE_FAST;
         default: scale = SCALE_MID;
      endcase
      bit_period = 24'((24'(divisor) + 24'h000001) * scale);
      next_acc   = acc + OVERSAMPLE;
   end

   // Sixteen ticks per bit while a bit spans 16 clocks or more; never more than one tick per clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc         <= 24'h000000;
         sample_tick <= 1'b0;
      end else if (!run) begin
         acc         <= 24'h000000;
         sample_tick <= 1'b0;
      end else if (next_acc >= bit_period) begin
         acc         <= next_acc - bit_period;
         sample_tick <= 1'b1;
      end else begin
         acc         <= next_acc;
         sample_tick <= 1'b0;
      end
   end

endmodule

//--- rtl/uart_rx_addr_detect_wake.sv
// Asynchronous serial receiver with address detect and wake on edge.
// Assumes an APB master on pclk and a receive line from another node.
// Contract
// - Asynchronous mode when sync clear, port enabled
// - Bit period from divisor bytes and selects
// - Nine-bit frames when enabled, ninth bit shown
// - Address detect on nine-bit frames when enabled
// - Without address detect, every frame loads, flags, unless the flag is still set (overrun)
// - Receive only while continuous receive is set
// - Flag on complete frame; interrupt needs enables
// - Framing, overrun and ninth bit in status
// - Clearing continuous receive clears error state
// - Sleep stops baud generator and reception
// - Wake enable arms edge detect in async
// - Wake enable suspends reception, receiver idles
// - Wake event is falling edge on line
// - Wake event sets the receive flag
// - Reading receive data clears the flag
// - Rising edge after wake clears wake enable
// - Sixteen-times oversampling feeds bit-rate shifter
`timescale 1ns/1ns
module uart_rx_addr_detect_wake
   import uart_rx_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        receive_line,
   input  wire logic        sleep_mode,
   output logic             irq_request
);

   // Control bits held by software
   logic       port_enable;                // Port on
   logic       nine_bit_receive_enable;    // Nine-bit frames
   logic       single_receive_enable;      // Stored only
   logic       continuous_receive_enable;  // Receiver on
   logic       address_detect_enable;      // Address filtering
   logic [7:0] tx_ctl;                     // Transmit control byte
   logic       wide_divisor_select;        // Baud scale select
   logic       wake_on_edge_enable;        // Wake detect armed
   logic [7:0] baud_divisor_high;          // Divisor high byte
   logic [7:0] baud_divisor_low;           // Divisor low byte
   logic       receive_interrupt_enable;   // Local enable
   logic       global_interrupt_enable;    // Global enable

   // Status held by hardware
   logic       framing_error_flag;         // Bad stop bit
   logic       overrun_error_flag;         // Frame lost
   logic       received_ninth_bit;         // Ninth data bit
   logic [7:0] receive_data_register;      // Received byte
   logic       receive_interrupt_flag;     // Frame or wake pending

   // Bus decode
   logic       wr_acc;       // Write access phase
   logic       rd_data_acc;  // Read of receive data
   logic       mapped;       // Address decodes
   logic [7:0] rd_mux;       // Read value of addressed register

   // Receive line and receiver state
   logic       rx_meta;      // First sync stage
   logic       rx_sync;      // Second sync stage
   logic       rx_prev;      // Previous synced level
   logic       sync_select;  // Synchronous mode chosen
   logic       async_on;     // Port enabled in async mode
   logic       rx_enable;    // Reception allowed
   logic       sample_tick;  // Sixteen-times bit rate tick
   rx_state_t  state;        // Receiver state
   rx_state_t  next_state;   // Next receiver state
   logic [3:0] tick_cnt;     // Ticks within a bit
   logic [3:0] bit_cnt;      // Data bits taken
   logic [3:0] last_bit;     // Index of final data bit
   logic [8:0] shift;        // Bit-rate data shifter
   logic [2:0] samples;      // Oversampling shifter
   logic       majority;     // Vote of three samples
   logic       frame_done;   // Stop bit sampled
   logic       stop_bad;     // Stop bit read low
   logic [7:0] frame_byte;   // Byte of the finished frame
   logic       frame_ninth;  // Ninth bit of the finished frame
   logic       accept;       // Frame passes address filter
   logic       load;         // Frame goes to the buffer
   logic       overrun;      // Frame arrives with buffer full
   logic       wake_seen;    // Falling edge seen, await rise
   logic       wake_fall;    // Wake event
   logic       wake_rise;    // End of wake character

   // Mode decode
   assign sync_select = tx_ctl[TS_SYNC];
   assign async_on    = port_enable & ~sync_select;
   assign rx_enable   = async_on & continuous_receive_enable
                      & ~wake_on_edge_enable
                      & ~sleep_mode
                      & ~overrun_error_flag;

   // APB handshake: always ready, error on unmapped address
   assign pready      = 1'b1;
   assign wr_acc      = psel & penable & pwrite;
   assign rd_data_acc = psel & penable & ~pwrite & (paddr == OFS_RX_DATA);
   assign pslverr     = psel & penable & ~mapped;

   // Two-stage synchroniser plus a previous-level stage; the first stage feeds no logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
         rx_prev <= 1'b1;
      end else begin
         rx_meta <= receive_line;
         rx_sync <= rx_meta;
         rx_prev <= rx_sync;
      end
   end

   // Baud generator, stopped whenever reception is not allowed
   rx_baud_gen u_baud (
      .pclk        (pclk),
      .presetn     (presetn),
      .run         (rx_enable),
      .high_speed  (tx_ctl[TS_HIGH]),
      .wide        (wide_divisor_select),
      .divisor     ({baud_divisor_high, baud_divisor_low}),
      .sample_tick (sample_tick)
   );

   // Sample vote and frame decode
   assign majority    = (samples[0] & samples[1]) | (samples[0] & samples[2])
                      | (samples[1] & samples[2]);
   assign last_bit    = nine_bit_receive_enable ? LAST_NINE : LAST_EIGHT;
   assign frame_done  = (state == ST_STOP) & sample_tick & rx_enable
                      & (tick_cnt == LAST_TICK);
   assign stop_bad    = ~majority;
   assign frame_byte  = nine_bit_receive_enable ? shift[7:0] : shift[8:1];
   assign frame_ninth = nine_bit_receive_enable & shift[8];
   assign accept      = frame_done & ~(address_detect_enable
                      & nine_bit_receive_enable & ~frame_ninth);
   assign load        = accept & ~receive_interrupt_flag;
   assign overrun     = accept & receive_interrupt_flag;

   // Next receiver state
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (!rx_sync) begin
               next_state = ST_START;
            end
         end
         ST_START: begin
            if (sample_tick && tick_cnt == MID_TICK) begin
               next_state = majority ? ST_IDLE : ST_DATA;
            end
         end
         ST_DATA: begin
            if (sample_tick && tick_cnt == LAST_TICK && bit_cnt == last_bit) begin
               next_state = ST_STOP;
            end
         end
         ST_STOP: begin
            if (frame_done) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // Receiver state; held idle while reception is not allowed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
      end else if (!rx_enable) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Oversampling shifter and bit-rate shifter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         samples  <= 3'h7;
         tick_cnt <= 4'h0;
         bit_cnt  <= 4'h0;
         shift    <= 9'h000;
      end else if (state == ST_IDLE) begin
         samples  <= 3'h7;
         tick_cnt <= 4'h0;
         bit_cnt  <= 4'h0;
      end else if (sample_tick) begin
         samples <= {samples[1:0], rx_sync};
         if (state == ST_START && tick_cnt == MID_TICK) begin
            tick_cnt <= 4'h0;
         end else begin
            tick_cnt <= tick_cnt + 4'h1;
         end
         if (state == ST_DATA && tick_cnt == LAST_TICK) begin
            shift   <= {majority, shift[8:1]};
            bit_cnt <= bit_cnt + 4'h1;
         end
      end
   end

   // Buffer, ninth bit and error flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         receive_data_register <= RESET_BYTE;
         received_ninth_bit    <= 1'b0;
         framing_error_flag    <= 1'b0;
         overrun_error_flag    <= 1'b0;
      end else if (!continuous_receive_enable) begin
         framing_error_flag <= 1'b0;
         overrun_error_flag <= 1'b0;
      end else begin
         if (load) begin
            receive_data_register <= frame_byte;
            received_ninth_bit    <= frame_ninth;
            framing_error_flag    <= stop_bad;
         end
         if (overrun) begin
            overrun_error_flag <= 1'b1;
         end
      end
   end

   // Wake edges, seen on the synced line while armed
   assign wake_fall = async_on & wake_on_edge_enable & ~wake_seen
                    & rx_prev & ~rx_sync;
   assign wake_rise = wake_seen & ~rx_prev & rx_sync;

   // Wake tracking between the falling and the rising edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_seen <= 1'b0;
      end else if (wake_fall) begin
         wake_seen <= 1'b1;
      end else if (wake_rise || !wake_on_edge_enable) begin
         wake_seen <= 1'b0;
      end
   end

   // Receive flag; a setting event wins over the clearing read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         receive_interrupt_flag <= 1'b0;
      end else if (load || wake_fall) begin
         receive_interrupt_flag <= 1'b1;
      end else if (rd_data_acc) begin
         receive_interrupt_flag <= 1'b0;
      end
   end

   // Interrupt request to the core
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_request <= 1'b0;
      end else begin
         irq_request <= receive_interrupt_flag & receive_interrupt_enable
                      & global_interrupt_enable;
      end
   end

   // Receive control written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_enable               <= 1'b0;
         nine_bit_receive_enable   <= 1'b0;
         single_receive_enable     <= 1'b0;
         continuous_receive_enable <= 1'b0;
         address_detect_enable     <= 1'b0;
      end else if (wr_acc && paddr == OFS_RX_STATUS) begin
         port_enable               <= pwdata[RS_PORT_EN];
         nine_bit_receive_enable   <= pwdata[RS_NINE];
         single_receive_enable     <= pwdata[RS_SINGLE];
         continuous_receive_enable <= pwdata[RS_CONT];
         address_detect_enable     <= pwdata[RS_ADDR];
      end
   end

   // Mode, divisor and interrupt enables written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_ctl                   <= RESET_BYTE;
         wide_divisor_select      <= 1'b0;
         baud_divisor_high        <= RESET_BYTE;
         baud_divisor_low         <= RESET_BYTE;
         receive_interrupt_enable <= 1'b0;
         global_interrupt_enable  <= 1'b0;
      end else if (wr_acc) begin
         case (paddr)
            OFS_TX_STATUS: tx_ctl <= pwdata[7:0];
            OFS_BAUD_CTRL: wide_divisor_select <= pwdata[BC_WIDE];
            OFS_DIV_HIGH:  baud_divisor_high <= pwdata[7:0];
            OFS_DIV_LOW:   baud_divisor_low <= pwdata[7:0];
            OFS_INT_CTRL: begin
               receive_interrupt_enable <= pwdata[IC_IE];
               global_interrupt_enable  <= pwdata[IC_GIE];
            end
            default: ;
         endcase
      end
   end

   // Wake enable: cleared by hardware at the end of the wake character
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_on_edge_enable <= 1'b0;
      end else if (wake_rise) begin
         wake_on_edge_enable <= 1'b0;
      end else if (wr_acc && paddr == OFS_BAUD_CTRL) begin
         wake_on_edge_enable <= pwdata[BC_WAKE];
      end
   end

   // Read multiplexer and address decode
   always_comb begin
      rd_mux = RESET_BYTE;
      mapped = 1'b1;
      case (paddr)
         OFS_RX_STATUS: begin
            rd_mux[RS_PORT_EN] = port_enable;
            rd_mux[RS_NINE]    = nine_bit_receive_enable;
            rd_mux[RS_SINGLE]  = single_receive_enable;
            rd_mux[RS_CONT]    = continuous_receive_enable;
            rd_mux[RS_ADDR]    = address_detect_enable;
            rd_mux[RS_FRAMING_ERROR_FLAG]    = framing_error_flag;
            rd_mux[RS_OVERRUN_ERROR_FLAG]    = overrun_error_flag;
            rd_mux[RS_NINTH]   = received_ninth_bit;
         end
         OFS_RX_DATA:   rd_mux = receive_data_register;
         OFS_TX_STATUS: rd_mux = tx_ctl;
         OFS_BAUD_CTRL: begin
            rd_mux[BC_IDLE] = (state == ST_IDLE);
            rd_mux[BC_WIDE] = wide_divisor_select;
            rd_mux[BC_WAKE] = wake_on_edge_enable;
         end
         OFS_DIV_HIGH:  rd_mux = baud_divisor_high;
         OFS_DIV_LOW:   rd_mux = baud_divisor_low;
         OFS_INT_CTRL: begin
            rd_mux[IC_FLAG] = receive_interrupt_flag;
            rd_mux[IC_IE]   = receive_interrupt_enable;
            rd_mux[IC_GIE]  = global_interrupt_enable;
         end
         default:       mapped = 1'b0;
      endcase
   end

   // Read data captured in the setup phase, stable through the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {24'h000000, rd_mux};
      end
   end

   // Checks on the receiver, flag and wake logic
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_async_only;
      !async_on |=> state == ST_IDLE;
   endproperty
   a_async_only: assert property (p_async_only)
      else $error("receiver left idle outside async mode");

   property p_cont_off;
      !continuous_receive_enable |=> state == ST_IDLE && !sample_tick;
   endproperty
   a_cont_off: assert property (p_cont_off)
      else $error("receiver ran without continuous receive");

   property p_sleep_stops;
      sleep_mode |=> !sample_tick ##0 state == ST_IDLE;
   endproperty
   a_sleep_stops: assert property (p_sleep_stops)
      else $error("baud tick during sleep");

   property p_wake_idle;
      wake_on_edge_enable |=> state == ST_IDLE;
   endproperty
   a_wake_idle: assert property (p_wake_idle)
      else $error("frame reception while wake enabled");

   property p_wake_flag;
      wake_fall |=> receive_interrupt_flag && wake_seen;
   endproperty
   a_wake_flag: assert property (p_wake_flag)
      else $error("wake event did not set flag");

   property p_read_clears;
      rd_data_acc && !load && !wake_fall |=> !receive_interrupt_flag;
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("data read did not clear flag");

   property p_wake_end;
      wake_rise |=> !wake_on_edge_enable ##1 !wake_seen;
   endproperty
   a_wake_end: assert property (p_wake_end)
      else $error("wake enable not cleared on rising edge");

   property p_err_clear;
      !continuous_receive_enable |=> !framing_error_flag && !overrun_error_flag;
   endproperty
   a_err_clear: assert property (p_err_clear)
      else $error("errors held with receiver off");

   property p_addr_drop;
      frame_done && !accept && !rd_data_acc
         |=> $stable(receive_data_register)
         && receive_interrupt_flag == $past(receive_interrupt_flag);
   endproperty
   a_addr_drop: assert property (p_addr_drop)
      else $error("data frame loaded in address mode");

   property p_load_status;
      load |=> receive_interrupt_flag
         && framing_error_flag == $past(stop_bad)
         && received_ninth_bit == $past(frame_ninth);
   endproperty
   a_load_status: assert property (p_load_status)
      else $error("status not taken from finished frame");

   property p_irq_gate;
      (receive_interrupt_flag && receive_interrupt_enable
         && global_interrupt_enable) [*2] |-> irq_request;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("enabled flag did not raise interrupt");

   c_load:    cover property (load);
   c_discard: cover property (frame_done && !accept);
   c_wake:    cover property (wake_fall ##[1:1000] wake_rise);
   c_overrun: cover property (overrun);

endmodule

//--- testbench/serial_node.sv
// Partner: a serial node driving the receive line, idle high.
// Assumes pclk is shared and bit_clocks gives clocks per bit.
`timescale 1ns/1ns
module serial_node (
   input  wire logic        pclk,
   input  wire logic [15:0] bit_clocks, // Clocks per bit
   output logic             line        // Serial out
);
   // Line rests high
   initial line = 1'b1;

   // Hold one level for some clocks
   task automatic hold(input logic level, input int clocks);
      line <= level;
      repeat (clocks) @(posedge pclk);
   endtask

   // Start, data LSB first, stop, two idle bits
   task automatic send(input logic [8:0] data, input int nbits,
                       input logic good_stop);
      hold(1'b0, bit_clocks);
      for (int i = 0; i < nbits; i++) begin
         hold(data[i], bit_clocks);
      end
      if (good_stop) begin
         hold(1'b1, bit_clocks);
      end else begin
         // Bad stop ends early so idle hunting sees high
         hold(1'b0, bit_clocks * 5 / 8);
      end
      hold(1'b1, bit_clocks * 2);
   endtask
endmodule

//--- testbench/test_uart_rx_addr_detect_wake.sv
// Bench for the serial receiver with address detect and wake.
// Assumes the package, design and partner node are compiled first.
`timescale 1ns/1ns
module test_uart_rx_addr_detect_wake
   import uart_rx_pkg::*;
();
   logic        pclk;         // Bus clock
   logic        presetn;      // Reset, active low
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        receive_line; // From partner
   logic        sleep_mode;
   logic        irq_request;
   logic [15:0] bit_clocks;   // Partner bit time
   logic [32:0] expect_q[$];  // Expected {pslverr, prdata}
   logic [7:0]  byte_a;       // Random payload
   int          errors;
   int          num_checks;
   int          seed;

   // 100 ns clock
   always #50 pclk = ~pclk;

   uart_rx_addr_detect_wake dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .receive_line(receive_line),
      .sleep_mode(sleep_mode), .irq_request(irq_request));

   serial_node node_u (.pclk(pclk), .bit_clocks(bit_clocks),
      .line(receive_line));

   // Compare and count
   task automatic check(input string name, input logic [32:0] seen,
                        input logic [32:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Verdict and end of run
   task automatic results();
      $display("Checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // One APB transfer, held until pready
   task automatic xfer(input logic wr, input logic [7:0] addr,
                       input logic [7:0] data);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= {24'h000000, data};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         errors++;
         results();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Read; expected word goes to the queue
   task automatic rd(input logic [7:0] addr, input logic [32:0] exp);
      expect_q.push_back(exp);
      xfer(1'b0, addr, 8'h00);
   endtask

   // Interrupt level as settled before the next edge
   task automatic irq_is(input logic exp);
      @(posedge pclk);
      check("irq_request", {32'h0, irq_request}, {32'h0, exp});
   endtask

   // Monitor: each finished read meets the oldest note
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready === 1'b1) begin
         if (expect_q.size() == 0) begin
            errors++;
            $display("Error read expected none seen %h", {pslverr, prdata});
         end else begin
            check("read", {pslverr, prdata}, expect_q.pop_front());
         end
      end
   end

   // Hang guard
   initial begin
      repeat (30000) @(posedge pclk);
      errors++;
      results();
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      sleep_mode = 1'b0;
      bit_clocks = 16'h0010;
      seed = 2;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(OFS_RX_STATUS, 33'h000);
      rd(OFS_BAUD_CTRL, 33'h040);
      rd(8'h1C, 33'h100000000);
      xfer(1'b1, OFS_DIV_LOW, 8'h03);
      xfer(1'b1, OFS_TX_STATUS, 8'h04);
      xfer(1'b1, OFS_BAUD_CTRL, 8'h08);
      xfer(1'b1, OFS_INT_CTRL, 8'h06);
      xfer(1'b1, OFS_RX_STATUS, 8'h90);
      repeat (4) begin
         byte_a = 8'($random(seed));
         node_u.send({1'b0, byte_a}, 8, 1'b1);
         irq_is(1'b1);
         rd(OFS_RX_DATA, {25'h0, byte_a});
         irq_is(1'b0);
      end
      // Slower setting: K 16, divisor 1, 32 clocks a bit
      xfer(1'b1, OFS_TX_STATUS, 8'h00);
      xfer(1'b1, OFS_DIV_LOW, 8'h01);
      bit_clocks = 16'h0020;
      byte_a = 8'($random(seed));
      node_u.send({1'b0, byte_a}, 8, 1'b1);
      rd(OFS_RX_DATA, {25'h0, byte_a});
      xfer(1'b1, OFS_TX_STATUS, 8'h04);
      xfer(1'b1, OFS_DIV_LOW, 8'h03);
      bit_clocks = 16'h0010;
      // Second frame unread is lost
      node_u.send(9'h0C3, 8, 1'b1);
      node_u.send(9'h03C, 8, 1'b1);
      rd(OFS_RX_STATUS, 33'h092);
      rd(OFS_RX_DATA, 33'h0C3);
      xfer(1'b1, OFS_RX_STATUS, 8'h80);
      rd(OFS_RX_STATUS, 33'h080);
      node_u.send(9'h055, 8, 1'b1);
      irq_is(1'b0);
      xfer(1'b1, OFS_RX_STATUS, 8'h90);
      node_u.send(9'h0F0, 8, 1'b0);
      rd(OFS_RX_STATUS, 33'h094);
      rd(OFS_RX_DATA, 33'h0F0);
      xfer(1'b1, OFS_RX_STATUS, 8'h80);
      rd(OFS_RX_STATUS, 33'h080);
      xfer(1'b1, OFS_RX_STATUS, 8'h90);
      xfer(1'b1, OFS_TX_STATUS, 8'h14);
      node_u.send(9'h055, 8, 1'b1);
      irq_is(1'b0);
      xfer(1'b1, OFS_TX_STATUS, 8'h04);
      sleep_mode <= 1'b1;
      node_u.send(9'h055, 8, 1'b1);
      irq_is(1'b0);
      sleep_mode <= 1'b0;
      // Address mode drops ninth-bit-zero frames
      xfer(1'b1, OFS_RX_STATUS, 8'hD8);
      node_u.send(9'h03C, 9, 1'b1);
      irq_is(1'b0);
      node_u.send(9'h1A5, 9, 1'b1);
      rd(OFS_RX_STATUS, 33'h0D9);
      rd(OFS_RX_DATA, 33'h0A5);
      xfer(1'b1, OFS_RX_STATUS, 8'hD0);
      node_u.send(9'h05A, 9, 1'b1);
      rd(OFS_RX_DATA, 33'h05A);
      // Wake from sleep on an all-zero character
      sleep_mode <= 1'b1;
      xfer(1'b1, OFS_BAUD_CTRL, 8'h0A);
      node_u.send(9'h000, 8, 1'b1);
      node_u.hold(1'b1, 64);
      irq_is(1'b1);
      rd(OFS_INT_CTRL, 33'h007);
      rd(OFS_BAUD_CTRL, 33'h048);
      rd(OFS_RX_DATA, 33'h05A);
      rd(OFS_INT_CTRL, 33'h006);
      sleep_mode <= 1'b0;
      // Reception resumes once the wake character has ended
      byte_a = 8'($random(seed));
      node_u.send({1'b1, byte_a}, 9, 1'b1);
      rd(OFS_RX_STATUS, 33'h0D1);
      rd(OFS_RX_DATA, {25'h0, byte_a});
      results();
   end
endmodule
